/* File: rtl/fsc_core.sv */
/*
  fsc_core: serial flash command block for latch control, status reads and
  writes, read parameters and the basic sequential read.
  Assumes the host drives cs_n_in and link_clk_in (mode 0), the array answers
  mem_data_in combinationally from mem_addr_out, and no frame runs during reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_core
  import fsc_pkg::*;
#(
  parameter int unsigned TW_CYC = TW_CYCLES,
  parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
) (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // serial link
  input wire logic link_clk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  // array read port
  output logic [23:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  // configuration and status
  input wire logic quad_mode_in,
  output logic busy_out,
  output logic write_enable_latch_out,
  output logic [15:0] status_out,
  output logic [3:0] dummy_count_out,
  output logic [3:0] wrap_length_out
);

  // ----------------------------------------------------------------
  // status merge
  // ----------------------------------------------------------------
  function automatic logic [15:0] sr_merge(input logic [15:0] old,
                                           input logic [15:0] raw,
                                           input logic vol);
    logic [15:0] m;
    m = (old & ~SR_WRITABLE) | (raw & SR_WRITABLE);
    m[BIT_LOCK] = m[BIT_LOCK] | old[BIT_LOCK];
    if (vol) begin
      m[BIT_PROTECT_B] = m[BIT_PROTECT_B] | old[BIT_PROTECT_B];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic fr_active;
  fsc_frame_t frm;
  logic [31:0] sh;
  logic [2:0] ph;
  logic load_now;
  logic load_mem;
  logic lk_tog;
  logic lk_ack_s1;
  logic lk_ack_s2;
  logic lk_ack;
  fsc_snap_t lk_snap;
  logic [7:0] osh;
  fsc_snap_t sys_snap;
  logic snap_tog;

  // shift and count decode
  wire lk_quad = lk_snap.quad;
  wire [5:0] step = lk_quad ? 6'h04 : 6'h01;
  wire [5:0] bits_base = fr_active ? frm.nbits : 6'h00;
  wire [5:0] bits_new = (bits_base >= FRM_SAT) ? bits_base : bits_base + step;
  wire [2:0] ph_new = (fr_active ? ph : 3'h0) + step[2:0];
  wire byte_done = (ph_new == 3'h0);
  wire [31:0] sh_new = lk_quad ? {sh[27:0], dq_in} : {sh[30:0], dq_in[0]};
  wire [7:0] cmd_now = (bits_new == FRM_CMD_END) ? sh_new[7:0] : frm.cmd;
  wire lk_stat_rd = (cmd_now == CMD_READ_STATUS_ONE) || (cmd_now == CMD_READ_STATUS_TWO);
  wire lk_rd = (cmd_now == CMD_READ) && !lk_snap.status[BIT_BUSY];
  // status byte reloaded at every byte boundary, busy or not
  wire stat_load = byte_done && (bits_new >= FRM_CMD_END) && lk_stat_rd;
  wire rd_load = byte_done && (bits_new >= FRM_ADDR_END) && lk_rd;
  wire [7:0] out_byte = load_mem ? mem_data_in :
                        (frm.cmd == CMD_READ_STATUS_TWO) ? lk_snap.status[15:8] :
                        lk_snap.status[7:0];
  wire [7:0] out_src = load_now ? out_byte : osh;

  // frame activity, cleared by chip select high
  always_ff @(posedge link_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fr_active <= 1'b0;
    end else begin
      fr_active <= 1'b1;
    end
  end

  // receive shifter and captured fields
  always_ff @(posedge link_clk_in or posedge srst_in) begin
    if (srst_in) begin
      frm <= '0;
      sh <= '0;
      ph <= '0;
      load_now <= 1'b0;
      load_mem <= 1'b0;
      mem_addr_out <= '0;
    end else begin
      sh <= sh_new;
      ph <= ph_new;
      frm.nbits <= bits_new;
      if (bits_new == FRM_CMD_END) begin
        frm.cmd <= sh_new[7:0];
      end
      if (bits_new == FRM_D0_END) begin
        frm.d0 <= sh_new[7:0];
      end
      if (bits_new == FRM_D1_END) begin
        frm.d1 <= sh_new[7:0];
      end
      load_now <= stat_load || rd_load;
      load_mem <= rd_load;
      if (rd_load) begin
        // first byte from the address, then one up per byte
        mem_addr_out <= (bits_new == FRM_ADDR_END) ? sh_new[23:0] : mem_addr_out + 24'h1;
      end
    end
  end

  // frame toggle and status snapshot handshake
  always_ff @(posedge link_clk_in or posedge srst_in) begin
    if (srst_in) begin
      lk_tog <= 1'b0;
      lk_ack_s1 <= 1'b0;
      lk_ack_s2 <= 1'b0;
      lk_ack <= 1'b0;
      lk_snap <= '0;
    end else begin
      // clocks with chip select high do not count as a frame start
      if (!fr_active && !cs_n_in) begin
        lk_tog <= ~lk_tog;
      end
      lk_ack_s1 <= snap_tog;
      lk_ack_s2 <= lk_ack_s1;
      if (lk_ack_s2 != lk_ack) begin
        lk_ack <= lk_ack_s2;
        lk_snap <= sys_snap;
      end
    end
  end

  // output shifter on falling edges, msb or high nibble first
  always_ff @(negedge link_clk_in or posedge cs_n_in or posedge srst_in) begin
    if (cs_n_in || srst_in) begin
      dq_out <= 4'h0;
      dq_oe_out <= 4'h0;
      osh <= 8'h00;
    end else begin
      dq_out <= lk_quad ? out_src[7:4] : {2'b00, out_src[7], 1'b0};
      osh <= lk_quad ? {out_src[3:0], 4'h0} : {out_src[6:0], 1'b0};
      if (load_now) begin
        dq_oe_out <= lk_quad ? 4'hf : 4'h2;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: synchronisers
  // ----------------------------------------------------------------
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tog_s1;
  logic tog_s2;
  logic tog_seen;
  logic ack_s1;
  logic ack_s2;
  logic quad_s1;
  logic quad_s2;

  wire frame_end = cs_s2 && !cs_s3;

  // two-flop capture of link levels
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_seen <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      quad_s1 <= 1'b0;
      quad_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tog_s1 <= lk_tog;
      tog_s2 <= tog_s1;
      ack_s1 <= lk_ack;
      ack_s2 <= ack_s1;
      quad_s1 <= quad_mode_in;
      quad_s2 <= quad_s1;
      if (frame_end) begin
        tog_seen <= tog_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: command execution
  // ----------------------------------------------------------------
  fsc_state_t st;
  logic [CNT_W-1:0] cnt;
  logic [15:0] pend;
  logic [15:0] sr;
  logic [15:0] sr_nv;
  logic write_enable_latch;
  logic vol_armed;
  logic rst_armed;
  logic [7:0] rparam;

  // frame decode; fields hold while chip select is high, until idle link clocks reload the bit count
  wire evt = frame_end && (tog_s2 != tog_seen) && (frm.nbits >= FRM_CMD_END);
  wire idle = (st == ST_IDLE);
  wire cmd_ok = evt && idle;
  wire [7:0] cmd = frm.cmd;
  wire data_ok = frm.nbits >= FRM_D0_END;
  wire stat_rd = (cmd == CMD_READ_STATUS_ONE) || (cmd == CMD_READ_STATUS_TWO);
  wire wr_cmd = ((cmd == CMD_WRITE_STATUS) || (cmd == CMD_WRITE_STATUS_TWO)) && data_ok;
  wire wr_hi = (cmd == CMD_WRITE_STATUS_TWO) || (frm.nbits >= FRM_D1_END);
  wire [7:0] raw_hi = (cmd == CMD_WRITE_STATUS_TWO) ? frm.d0 : frm.d1;
  wire [15:0] raw = {wr_hi ? raw_hi : sr[15:8],
                     (cmd == CMD_WRITE_STATUS) ? frm.d0 : sr[7:0]};
  wire [15:0] new_nv = sr_merge(sr, raw, 1'b0);
  wire [15:0] new_vol = sr_merge(sr, raw, 1'b1);
  wire [15:0] new_sr = vol_armed ? new_vol : new_nv;
  wire reject = quad_s2 && !new_sr[BIT_QUAD_ENABLE];
  wire go_nv = cmd_ok && wr_cmd && !vol_armed && write_enable_latch && !reject;
  wire go_vol = cmd_ok && wr_cmd && vol_armed && !reject;
  wire do_reset = cmd_ok && (cmd == CMD_RESET) && rst_armed;
  wire done = !idle && (cnt == '0);
  wire [15:0] st_word = {sr[15:2], write_enable_latch, st == ST_NV_WRITE};

  // write cycle sequencer
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st <= ST_IDLE;
      cnt <= '0;
      pend <= '0;
    end else if (go_nv) begin
      st <= ST_NV_WRITE;
      cnt <= CNT_W'(TW_CYC - 1);
      pend <= new_sr;
    end else if (go_vol) begin
      st <= ST_VOL_REFRESH;
      cnt <= CNT_W'(REFRESH_CYC - 1);
      pend <= new_sr;
    end else if (done) begin
      st <= ST_IDLE;
    end else if (!idle) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

  // active and non-volatile status copies
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sr <= SR_NV_RESET;
      sr_nv <= SR_NV_RESET;
    end else if (done) begin
      sr <= pend;
      if (st == ST_NV_WRITE) begin
        sr_nv <= pend;
      end
    end else if (do_reset) begin
      sr <= sr_nv;
    end
  end

  // write enable latch
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      write_enable_latch <= 1'b0;
    end else if (done && (st == ST_NV_WRITE)) begin
      write_enable_latch <= 1'b0;
    end else if (cmd_ok && (cmd == CMD_WRITE_ENABLE)) begin
      write_enable_latch <= 1'b1;
    end else if (cmd_ok && (cmd == CMD_WRITE_DISABLE)) begin
      write_enable_latch <= 1'b0;
    end else if (do_reset) begin
      write_enable_latch <= 1'b0;
    end
  end

  // one-shot arming by volatile enable and reset enable
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      vol_armed <= 1'b0;
      rst_armed <= 1'b0;
    end else if (cmd_ok) begin
      vol_armed <= (cmd == CMD_VOL_WRITE_ENABLE) || (stat_rd && vol_armed);
      rst_armed <= (cmd == CMD_RESET_ENABLE) || (stat_rd && rst_armed);
    end
  end

  // read parameters for quad mode reads
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rparam <= READ_PARAM_RESET;
    end else if (cmd_ok && (cmd == CMD_SET_READ_PARAM) && data_ok) begin
      rparam <= frm.d0;
    end else if (do_reset) begin
      rparam <= READ_PARAM_RESET;
    end
  end

  // registered outputs and snapshot towards the link
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      status_out <= '0;
      dummy_count_out <= '0;
      wrap_length_out <= '0;
      sys_snap <= '0;
      snap_tog <= 1'b0;
    end else begin
      busy_out <= (st == ST_NV_WRITE);
      write_enable_latch_out <= write_enable_latch;
      status_out <= st_word;
      dummy_count_out <= rparam[7:4];
      wrap_length_out <= rparam[3:0];
      if ((ack_s2 == snap_tog) && (sys_snap != {quad_s2, st_word})) begin
        sys_snap <= {quad_s2, st_word};
        snap_tog <= ~snap_tog;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/fsc_pkg.sv */
/*
  fsc_pkg: command codes, status layout, frame carriers and timing for the
  serial flash status, write-enable and basic read command block.
  Assumes a 125 MHz system clock; the link clock is made by the host.
*/
// Notes on behaviour
// - quad mode: command two clocks, address six, each byte two, high nibble first
// - quad mode: dummy clocks for fast and wrapped reads from upper read-param nibble
// - quad mode: wrap length of wrapped burst read from lower read-param nibble
// - write-enable code sets the write enable latch once chip select rises
// - volatile write-enable leaves the latch alone, arms next status write as volatile
// - write-disable code framed by chip select clears the write enable latch
// - latch clears at power-up and when non-volatile status write or reset completes
// - status read codes shift that register out on falling edges, msb first
// - status reads work at any time, even busy, until chip select rises
// - status writes touch only bits 7..2 and 14, 12..8
// - lock bit is one-time programmable: once 1 writes never clear it; a lock set only by a volatile write is cleared by the reset command; srst_in clears it
// - non-volatile status write needs write-enable first, then code and data
// - volatile status write keeps latch 0; protect bit b and lock never fall
// - reset command restores status from the non-volatile copy
// - non-volatile status write runs a timed busy cycle, then clears busy and latch
// - volatile status write applies after a short refresh with busy kept 0
// - in quad mode a status write clearing quad enable is rejected
// - basic read: code and 24-bit address in, bytes out on falling edges msb first
// - basic read increments the address per byte and streams until chip select rises
// - basic read while busy is ignored and the running cycle is untouched
// - status value repeats continuously until chip select rises
package fsc_pkg;

  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h35;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_STATUS_TWO = 8'h31;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_SET_READ_PARAM = 8'hc0;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;

  // status layout
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_PROTECT_B = 8;
  localparam int BIT_QUAD_ENABLE = 9;
  localparam int BIT_LOCK = 10;
  localparam logic [15:0] SR_WRITABLE = 16'h5ffc;
  localparam logic [15:0] SR_NV_RESET = 16'h0000;
  localparam logic [7:0] READ_PARAM_RESET = 8'h00;

  // frame bit marks
  localparam logic [5:0] FRM_CMD_END = 6'h08;
  localparam logic [5:0] FRM_D0_END = 6'h10;
  localparam logic [5:0] FRM_D1_END = 6'h18;
  localparam logic [5:0] FRM_ADDR_END = 6'h20;
  localparam logic [5:0] FRM_SAT = 6'h28;

  // timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TW_NS = 1000000;
  localparam int unsigned TSHSL2_NS = 50;
  localparam int unsigned TW_CYCLES = (TW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REFRESH_CYCLES =
    (TSHSL2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [5:0] nbits;
  } fsc_frame_t;

  typedef struct packed {
    logic quad;
    logic [15:0] status;
  } fsc_snap_t;

  typedef enum logic [1:0] {ST_IDLE, ST_NV_WRITE, ST_VOL_REFRESH} fsc_state_t;

endpackage

/* File: tb/fsc_core_assertions.sv */
/*
  checker for the fsc_core ports, bound to every fsc_core instance.
  assumes the system clock domain only; link-side ports are sampled.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_core_assertions
  import fsc_pkg::*;
#(
  parameter int unsigned TW_CYC = TW_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // link side
  input wire logic cs_n_in,
  input wire logic [3:0] dq_oe_out,
  // status side
  input wire logic busy_out,
  input wire logic write_enable_latch_out,
  input wire logic [15:0] status_out,
  input wire logic [3:0] dummy_count_out
);
  logic [23:0] busy_cnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // length of the running busy cycle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !busy_out) begin
      busy_cnt <= 24'h0;
    end else begin
      busy_cnt <= busy_cnt + 24'h1;
    end
  end
  latch_mirror_a: assert property (status_out[BIT_LATCH] == write_enable_latch_out)
    else $error("latch bit and latch port differ");
  busy_mirror_a: assert property (status_out[BIT_BUSY] == busy_out)
    else $error("busy bit and busy port differ");
  fixed_bits_a: assert property (status_out[15] == 1'b0 && status_out[13] == 1'b0)
    else $error("read-only status bit changed");
  busy_length_a: assert property ($fell(busy_out) |-> busy_cnt == 24'(TW_CYC))
    else $error("busy cycle length wrong");
  busy_end_latch_a: assert property ($fell(busy_out) |-> !write_enable_latch_out)
    else $error("latch still set after busy cycle");
  busy_needs_latch_a: assert property ($rose(busy_out) |-> write_enable_latch_out)
    else $error("busy cycle began without latch");
  idle_release_a: assert property (cs_n_in [*3] |-> dq_oe_out == 4'h0)
    else $error("output enabled while deselected");
  oe_shape_a: assert property (dq_oe_out inside {4'h0, 4'h2, 4'hf})
    else $error("illegal output enable pattern");
  latch_after_cs_a: assert property ($rose(write_enable_latch_out)
    |-> cs_n_in && $past(cs_n_in, 3))
    else $error("latch set before frame ended");
  param_hold_a: assert property (busy_out && $past(busy_out) |-> $stable(dummy_count_out))
    else $error("read parameter changed while busy");
endmodule
bind fsc_core fsc_core_assertions #(.TW_CYC(TW_CYC)) fsc_core_assertions_inst (
  .sys_clk_in(sys_clk_in),
  .srst_in(srst_in),
  .cs_n_in(cs_n_in),
  .dq_oe_out(dq_oe_out),
  .busy_out(busy_out),
  .write_enable_latch_out(write_enable_latch_out),
  .status_out(status_out),
  .dummy_count_out(dummy_count_out)
);
`default_nettype wire

/* File: tb/fsc_host.sv */
/*
  fsc_host: behavioural serial host driving chip select, link clock, data.
  assumes mode 0; the link clock rests low outside frames except for idle clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_host (
  // link to the device
  output logic link_clk_out,
  output logic cs_n_out,
  output logic [3:0] dq_out,
  input wire logic [3:0] dev_dq_in,
  input wire logic [3:0] dev_oe_in
);
  localparam realtime HALF = 62.5;
  // octal-word quad read code: start address must be 16-byte aligned
  localparam logic [7:0] OCT_READ = 8'he3;
  logic saw_oe;
  // idle levels
  initial begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b1;
    dq_out = 4'h5;
    saw_oe = 1'b0;
  end
  // one frame: nb bits out msb first, then nrx reply clocks
  task automatic frame(input logic [31:0] tx, input int nb, input int nrx,
                       input logic quad, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    saw_oe = 1'b0;
    if (tx[31:24] == OCT_READ) begin
      tx[3:0] = 4'h0;
    end
    #1.3;
    cs_n_out = 1'b0;
    for (i = 0; i < nb; i += (quad ? 4 : 1)) begin
      if (quad) begin
        dq_out = tx[31-i -: 4];
      end else begin
        dq_out = {~dq_out[3:1], tx[31-i]};
      end
      #HALF link_clk_out = 1'b1;
      #HALF link_clk_out = 1'b0;
    end
    for (i = 0; i < nrx; i++) begin
      dq_out = ~dq_out;
      #HALF link_clk_out = 1'b1;
      rx = quad ? {rx[27:0], dev_dq_in} : {rx[30:0], dev_dq_in[1]};
      saw_oe = saw_oe | (|dev_oe_in);
      #HALF link_clk_out = 1'b0;
    end
    #HALF cs_n_out = 1'b1;
  endtask
  // clocks with chip select high, to carry the mode setting across
  task automatic idle(input int n);
    repeat (n) begin
      #HALF link_clk_out = 1'b1;
      #HALF link_clk_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/test_flash_status_and_read_cmds.sv */
/*
  test_flash_status_and_read_cmds: self-checking bench for fsc_core.
  assumes fsc_host as the far side and a combinational array model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_flash_status_and_read_cmds
  import fsc_pkg::*;
;
  logic sys_clk_in, srst_in, link_clk, cs_n, quad_mode, busy, latch;
  logic [3:0] dq_in, dq_out, dq_oe, dummy, wrap;
  logic [23:0] mem_addr;
  logic [7:0] mem_data;
  logic [15:0] status;
  logic [31:0] rx;
  int fails, tests_run;
  // array contents follow the address
  assign mem_data = mem_addr[7:0] + mem_addr[15:8];
  fsc_host fsc_host_inst (.link_clk_out(link_clk), .cs_n_out(cs_n), .dq_out(dq_in),
    .dev_dq_in(dq_out), .dev_oe_in(dq_oe));
  fsc_core #(.TW_CYC(2000)) fsc_core_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .link_clk_in(link_clk), .cs_n_in(cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe), .mem_addr_out(mem_addr), .mem_data_in(mem_data),
    .quad_mode_in(quad_mode), .busy_out(busy), .write_enable_latch_out(latch),
    .status_out(status), .dummy_count_out(dummy), .wrap_length_out(wrap));
  // system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one frame, then time for the effects to land
  task automatic fr(input logic [31:0] tx, input int nb, input int nrx = 0);
    fsc_host_inst.frame(tx, nb, nrx, quad_mode, rx);
    repeat (16) @(negedge sys_clk_in);
  endtask
  task automatic t_latch;
    `CHK("status after reset", 16'h0000, status)
    fr({CMD_WRITE_ENABLE, 24'h0}, 8);
    `CHK("latch after enable", 1'b1, latch)
    fr({CMD_VOL_WRITE_ENABLE, 24'h0}, 8);
    `CHK("latch after vol enable", 1'b1, latch)
    fr({CMD_WRITE_DISABLE, 24'h0}, 8);
    `CHK("latch after disable", 1'b0, latch)
    fr({CMD_WRITE_ENABLE, 24'h0}, 7);
    `CHK("latch after short frame", 1'b0, latch)
    $display("test latch done");
  endtask
  task automatic t_read;
    fr({CMD_READ, 24'h0000fe}, 32, 24);
    `CHK("read stream", 24'hfeff01, rx[23:0])
    $display("test read done");
  endtask
  task automatic t_nvw;
    int n;
    fr({CMD_WRITE_ENABLE, 24'h0}, 8);
    fr({CMD_WRITE_STATUS, 16'hffff, 8'h0}, 24);
    `CHK("busy after nv write", 1'b1, busy)
    fr({CMD_READ_STATUS_ONE, 24'h0}, 8, 16);
    `CHK("status read while busy", 16'h0303, rx[15:0])
    fr({CMD_READ, 24'h000010}, 32, 8);
    `CHK("read drive while busy", 1'b0, fsc_host_inst.saw_oe)
    fr({CMD_SET_READ_PARAM, 8'h3c, 16'h0}, 16);
    `CHK("dummy kept while busy", 4'h0, dummy)
    `CHK("wrap kept while busy", 4'h0, wrap)
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge sys_clk_in);
    `CHK("busy cycle ends", 1'b0, busy)
    `CHK("status after nv write", 16'h5ffc, status)
    `CHK("latch after nv write", 1'b0, latch)
    $display("test nv write done");
  endtask
  task automatic t_refuse;
    fr({CMD_WRITE_STATUS, 16'h0000, 8'h0}, 24);
    `CHK("write without latch", 16'h5ffc, status)
    fr({CMD_READ_STATUS_TWO, 24'h0}, 8, 16);
    `CHK("status two repeats", 16'h5f5f, rx[15:0])
    fr({CMD_READ_STATUS_ONE, 24'h0}, 8, 16);
    `CHK("status one repeats", 16'hfcfc, rx[15:0])
    $display("test refuse done");
  endtask
  task automatic t_quad;
    quad_mode = 1'b1;
    fsc_host_inst.idle(8);
    fr({CMD_SET_READ_PARAM, 8'ha5, 16'h0}, 16);
    `CHK("dummy count", 4'ha, dummy)
    `CHK("wrap length", 4'h5, wrap)
    fr({CMD_VOL_WRITE_ENABLE, 24'h0}, 8);
    fr({CMD_WRITE_STATUS, 16'hfc00, 8'h0}, 24);
    `CHK("quad enable kept", 16'h5ffc, status)
    fr({CMD_READ_STATUS_TWO, 24'h0}, 8, 4);
    `CHK("quad status read", 16'h5f5f, rx[15:0])
    quad_mode = 1'b0;
    fsc_host_inst.idle(8);
    $display("test quad done");
  endtask
  task automatic t_vol;
    fr({CMD_VOL_WRITE_ENABLE, 24'h0}, 8);
    fr({CMD_WRITE_STATUS, 16'h0000, 8'h0}, 24);
    `CHK("busy in vol write", 1'b0, busy)
    `CHK("status after vol write", 16'h0500, status)
    `CHK("latch in vol write", 1'b0, latch)
    fr({CMD_RESET_ENABLE, 24'h0}, 8);
    fr({CMD_RESET, 24'h0}, 8);
    `CHK("status after reset cmd", 16'h5ffc, status)
    fr({CMD_VOL_WRITE_ENABLE, 24'h0}, 8);
    fr({CMD_WRITE_STATUS_TWO, 8'h00, 16'h0}, 16);
    `CHK("status two vol write", 16'h05fc, status)
    fr({CMD_VOL_WRITE_ENABLE, 24'h0}, 8);
    fr({CMD_WRITE_STATUS, 8'h00, 16'h0}, 16);
    `CHK("one byte vol write", 16'h0500, status)
    $display("test vol write done");
  endtask
  // main sequence
  initial begin
    srst_in = 1'b1;
    quad_mode = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (8) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    t_latch;
    t_read;
    t_nvw;
    t_refuse;
    t_quad;
    t_vol;
    close_out;
  end
  // watchdog
  initial begin
    #400000;
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
